//--- logic/acmp_defs.vh
// Register map, field layout and timing constants of the comparator control block
`ifndef ACMP_DEFS_VH
`define ACMP_DEFS_VH

`define OFF_GLOBAL_CTRL 8'h00
`define OFF_START 8'h04
`define OFF_OUT_STATE 8'h08
`define OFF_READY 8'h0C
`define OFF_IRQ_STATUS 8'h10
`define OFF_IRQ_ENABLE 8'h14
`define OFF_IRQ_CLEAR 8'h18
`define OFF_CHAN_CTRL0 8'h20

// Channel control field positions
`define CC_ENABLE 0
`define CC_SINGLE 1
`define CC_SPEED_LO 2
`define CC_SPEED_HI 3
`define CC_IRQSEL_LO 4
`define CC_IRQSEL_HI 5
`define CC_HYSTERESIS 6
`define CC_STANDBY 7
`define CC_POS_LO 8
`define CC_POS_HI 10
`define CC_NEG_LO 12
`define CC_NEG_HI 14
`define CC_FILT_LO 16
`define CC_FILT_HI 18
`define CC_WMASK 32'h0007_77FE

`define IRQSEL_TOGGLE 2'h0
`define IRQSEL_RISE 2'h1
`define IRQSEL_FALL 2'h2
`define IRQSEL_EOC 2'h3

`define RESET_WORD 32'h0000_0000
`define STARTUP_CYCLES 16

`endif

//--- logic/analog_comparator_control.v
// Comparator channel sequencing with AXI4-Lite register access
`timescale 1ns/1ps
`include "acmp_defs.vh"

module analog_comparator_control #(
    parameter NCH = 2,
    parameter STARTUP_CYCLES = `STARTUP_CYCLES
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Analog core
    input wire [NCH-1:0] comp_out,
    output reg [NCH-1:0] core_power_on,
    output reg [NCH-1:0] core_sample,
    output reg [3*NCH-1:0] positive_input_select,
    output reg [3*NCH-1:0] negative_input_select,
    output reg [NCH-1:0] hysteresis_select,
    output reg [2*NCH-1:0] speed_select,
    output reg [3*NCH-1:0] output_filter_length,
    output reg [NCH-1:0] keep_running_in_standby,
    // Events and interrupt
    output reg [NCH-1:0] event_out,
    output reg [NCH-1:0] eoc_event,
    output wire irq
);

    // Sequencer states; IDLE holds a single-shot result until the next start
    localparam ST_OFF = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_RUN = 2'd2;
    localparam ST_IDLE = 2'd3;
    localparam CW = 16;

    reg global_enable_q;
    reg [31:0] chan_ctrl_q [0:NCH-1];
    reg [1:0] st_q [0:NCH-1];
    reg [CW-1:0] cnt_q [0:NCH-1];
    reg [NCH-1:0] state_q;
    reg [NCH-1:0] ready_q;
    reg [NCH-1:0] start_req_q;
    reg [NCH-1:0] irq_status_q;
    reg [NCH-1:0] irq_enable_q;
    reg have_aw_q;
    reg have_w_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    // A write commits once both halves are held and the last response has gone
    wire do_write = have_aw_q && have_w_q && !s_axi_bvalid;
    // Clear strobes come from byte 0 of a write to the clear register
    wire irq_clear_hit = do_write && (awaddr_q == `OFF_IRQ_CLEAR) && wstrb_q[0];
    wire [NCH-1:0] irq_clear = irq_clear_hit ? wdata_q[NCH-1:0] : {NCH{1'b0}};
    wire [NCH-1:0] ch_run;
    reg [NCH-1:0] irq_hit;
    reg [NCH-1:0] compare_now;

    // A held half drops its ready, so the master keeps offering only the other
    assign s_axi_awready = !have_aw_q && !s_axi_bvalid;
    assign s_axi_wready = !have_w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq = |(irq_status_q & irq_enable_q);

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[8*b +: 8] = data[8*b +: 8];
                end
            end
        end
    endfunction

    function is_chan;
        input [7:0] addr;
        input integer ch;
        begin
            is_chan = (addr == `OFF_CHAN_CTRL0 + ch[5:0] * 4);
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : chan
            // Global enable gates cores without touching channel enable bits
            assign ch_run[g] = global_enable_q && chan_ctrl_q[g][`CC_ENABLE];
        end
    endgenerate

    // Compare strobe and interrupt condition per channel
    always @* begin : hit_calc
        integer i;
        i = 0;
        irq_hit = {NCH{1'b0}};
        compare_now = {NCH{1'b0}};
        for (i = 0; i < NCH; i = i + 1) begin
            compare_now[i] = ch_run[i] &&
                ((st_q[i] == ST_START && cnt_q[i] == STARTUP_CYCLES - 1) ||
                 st_q[i] == ST_RUN);
            if (compare_now[i]) begin
                // Edge conditions need an earlier result, so the first one is no edge
                case (chan_ctrl_q[i][`CC_IRQSEL_HI:`CC_IRQSEL_LO])
                    `IRQSEL_TOGGLE: irq_hit[i] = ready_q[i] && (comp_out[i] != state_q[i]);
                    `IRQSEL_RISE: irq_hit[i] = ready_q[i] && comp_out[i] && !state_q[i];
                    `IRQSEL_FALL: irq_hit[i] = ready_q[i] && !comp_out[i] && state_q[i];
                    default: irq_hit[i] = 1'b1;
                endcase
            end
        end
    end

    // Channel sequencers
    always @(posedge aclk) begin : chan_seq
        integer i;
        if (!aresetn) begin
            for (i = 0; i < NCH; i = i + 1) begin
                st_q[i] <= ST_OFF;
                cnt_q[i] <= {CW{1'b0}};
            end
            state_q <= {NCH{1'b0}};
            ready_q <= {NCH{1'b0}};
            event_out <= {NCH{1'b0}};
            eoc_event <= {NCH{1'b0}};
            core_power_on <= {NCH{1'b0}};
            core_sample <= {NCH{1'b0}};
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                core_power_on[i] <= ch_run[i];
                core_sample[i] <= compare_now[i];
                // Events follow the comparator state, independent of irq enable
                event_out[i] <= compare_now[i] && ready_q[i] &&
                    (comp_out[i] != state_q[i]);
                eoc_event[i] <= compare_now[i];
                if (compare_now[i]) begin
                    state_q[i] <= comp_out[i];
                    ready_q[i] <= 1'b1;
                end
                // Disable drops ready but keeps the last state for software
                if (!ch_run[i]) begin
                    st_q[i] <= ST_OFF;
                    cnt_q[i] <= {CW{1'b0}};
                    ready_q[i] <= 1'b0;
                end else begin
                    case (st_q[i])
                        ST_OFF: begin
                            // Single-shot waits for a start request before warm-up; the core is already powered
                            if (!chan_ctrl_q[i][`CC_SINGLE] || start_req_q[i]) begin
                                st_q[i] <= ST_START;
                                cnt_q[i] <= {CW{1'b0}};
                            end
                        end
                        ST_START: begin
                            // Core output unusable until the count expires
                            if (cnt_q[i] == STARTUP_CYCLES - 1) begin
                                st_q[i] <= chan_ctrl_q[i][`CC_SINGLE] ? ST_IDLE : ST_RUN;
                            end else begin
                                cnt_q[i] <= cnt_q[i] + 1'b1;
                            end
                        end
                        ST_RUN: st_q[i] <= ST_RUN;
                        default: begin
                            // Single-shot done; a new start repeats with warm-up
                            if (start_req_q[i]) begin
                                st_q[i] <= ST_START;
                                cnt_q[i] <= {CW{1'b0}};
                            end
                        end
                    endcase
                end
            end
        end
    end

    // Register file, write side
    always @(posedge aclk) begin : reg_write
        integer i;
        if (!aresetn) begin
            have_aw_q <= 1'b0;
            have_w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= `RESET_WORD;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            global_enable_q <= 1'b0;
            start_req_q <= {NCH{1'b0}};
            irq_enable_q <= {NCH{1'b0}};
            for (i = 0; i < NCH; i = i + 1) begin
                chan_ctrl_q[i] <= `RESET_WORD;
            end
        end else begin
            // Start is a one-cycle pulse; a start to a disabled channel is lost
            start_req_q <= {NCH{1'b0}};
            if (s_axi_awvalid && s_axi_awready) begin
                have_aw_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                have_w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                have_aw_q <= 1'b0;
                have_w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (awaddr_q == `OFF_GLOBAL_CTRL) begin
                    if (wstrb_q[0]) global_enable_q <= wdata_q[0];
                end else if (awaddr_q == `OFF_START) begin
                    if (wstrb_q[0]) start_req_q <= wdata_q[NCH-1:0];
                end else if (awaddr_q == `OFF_IRQ_ENABLE) begin
                    if (wstrb_q[0]) irq_enable_q <= wdata_q[NCH-1:0];
                end else if (awaddr_q == `OFF_IRQ_CLEAR ||
                             awaddr_q == `OFF_OUT_STATE ||
                             awaddr_q == `OFF_READY ||
                             awaddr_q == `OFF_IRQ_STATUS) begin
                    s_axi_bresp <= 2'b00;
                end else begin
                    s_axi_bresp <= 2'b10;
                end
                for (i = 0; i < NCH; i = i + 1) begin
                    if (is_chan(awaddr_q, i)) begin
                        s_axi_bresp <= 2'b00;
                        if (chan_ctrl_q[i][`CC_ENABLE]) begin
                            // Only the enable bit is writable while enabled
                            if (wstrb_q[0]) begin
                                chan_ctrl_q[i][`CC_ENABLE] <= wdata_q[`CC_ENABLE];
                            end
                        end else begin
                            // Fields and enable in one write: both land in the same cycle
                            chan_ctrl_q[i] <= merge(chan_ctrl_q[i], wdata_q,
                                wstrb_q) & (`CC_WMASK | 32'h0000_0001);
                        end
                    end
                end
            end
        end
    end

    // Sticky flags; a set in the clear cycle wins so no event is lost
    always @(posedge aclk) begin : irq_flags
        integer i;
        if (!aresetn) begin
            irq_status_q <= {NCH{1'b0}};
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                if (irq_hit[i]) begin
                    irq_status_q[i] <= 1'b1;
                end else if (irq_clear[i]) begin
                    irq_status_q[i] <= 1'b0;
                end
            end
        end
    end

    // Channel fields driven to the analog core
    always @* begin : field_out
        integer i;
        i = 0;
        for (i = 0; i < NCH; i = i + 1) begin
            hysteresis_select[i] = chan_ctrl_q[i][`CC_HYSTERESIS];
            keep_running_in_standby[i] = chan_ctrl_q[i][`CC_STANDBY];
            speed_select[2*i +: 2] = chan_ctrl_q[i][`CC_SPEED_HI:`CC_SPEED_LO];
            positive_input_select[3*i +: 3] = chan_ctrl_q[i][`CC_POS_HI:`CC_POS_LO];
            negative_input_select[3*i +: 3] = chan_ctrl_q[i][`CC_NEG_HI:`CC_NEG_LO];
            output_filter_length[3*i +: 3] = chan_ctrl_q[i][`CC_FILT_HI:`CC_FILT_LO];
        end
    end

    // Register file, read side
    always @(posedge aclk) begin : reg_read
        integer i;
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RESET_WORD;
            s_axi_rresp <= 2'b00;
        end else begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                s_axi_rdata <= `RESET_WORD;
                if (s_axi_araddr == `OFF_GLOBAL_CTRL) begin
                    s_axi_rdata[0] <= global_enable_q;
                end else if (s_axi_araddr == `OFF_OUT_STATE) begin
                    s_axi_rdata[NCH-1:0] <= state_q;
                end else if (s_axi_araddr == `OFF_READY) begin
                    s_axi_rdata[NCH-1:0] <= ready_q;
                end else if (s_axi_araddr == `OFF_IRQ_STATUS) begin
                    s_axi_rdata[NCH-1:0] <= irq_status_q;
                end else if (s_axi_araddr == `OFF_IRQ_ENABLE) begin
                    s_axi_rdata[NCH-1:0] <= irq_enable_q;
                // Write-only offsets read as zero with an OKAY answer
                end else if (s_axi_araddr == `OFF_START ||
                             s_axi_araddr == `OFF_IRQ_CLEAR) begin
                    s_axi_rresp <= 2'b00;
                end else begin
                    s_axi_rresp <= 2'b10;
                end
                for (i = 0; i < NCH; i = i + 1) begin
                    if (is_chan(s_axi_araddr, i)) begin
                        s_axi_rresp <= 2'b00;
                        s_axi_rdata <= chan_ctrl_q[i];
                    end
                end
            end
        end
    end

endmodule // analog_comparator_control

//--- test/acmp_props.sv
// Port-level checks of the comparator control block
`timescale 1ns/1ps
module acmp_props #(parameter NCH = 2, parameter STARTUP_CYCLES = 16) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Register bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Core side
    input wire [NCH-1:0] core_power_on,
    input wire [NCH-1:0] core_sample,
    input wire [3*NCH-1:0] positive_input_select,
    input wire [NCH-1:0] eoc_event,
    input wire [NCH-1:0] event_out,
    input wire irq
);
    logic [7:0] pwr_cnt_q;
    // Saturates so a long run cannot wrap into a false warm-up
    always @(posedge aclk) begin
        if (!aresetn || !core_power_on[0])
            pwr_cnt_q <= 8'h00;
        else if (pwr_cnt_q != 8'hFF)
            pwr_cnt_q <= pwr_cnt_q + 8'h01;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response missing");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    a_warmup_first: assert property (core_sample[0] |-> pwr_cnt_q >= STARTUP_CYCLES - 1)
        else $error("comparison before warm-up");
    a_eoc_follows: assert property (core_sample[0] |-> ##[0:2] eoc_event[0])
        else $error("comparison without end event");
    a_config_frozen: assert property (core_power_on[0] && $past(core_power_on[0]) |->
        $stable(positive_input_select[2:0])) else $error("config moved while on");
    c_single: cover property (core_sample[1]);
    c_irq: cover property (irq);
    c_event: cover property (event_out[0]);
endmodule // acmp_props

bind analog_comparator_control acmp_props #(.NCH(NCH), .STARTUP_CYCLES(STARTUP_CYCLES))
    props_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .core_power_on, .core_sample, .positive_input_select,
    .eoc_event, .event_out, .irq);

//--- test/acmp_core_model.sv
// Behavioural model of the analog comparator core
`timescale 1ns/1ps
module acmp_core_model #(parameter NCH = 2) (
    // Clock
    input wire aclk,
    // Power from the block and level set by the bench
    input wire [NCH-1:0] core_power_on,
    input wire [NCH-1:0] level,
    // Result
    output logic [NCH-1:0] comp_out
);
    initial comp_out = '0;
    // Unpowered channels toggle so a result used without power shows up
    always @(posedge aclk) begin
        for (int i = 0; i < NCH; i++)
            comp_out[i] <= core_power_on[i] ? level[i] : ~comp_out[i];
    end
endmodule // acmp_core_model

//--- test/analog_comparator_control_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "acmp_defs.vh"
module analog_comparator_control_tb;
    localparam SU = 2;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [1:0] level, comp_out, pwr, smp, evt, eoc, hys, stby;
    logic [5:0] pos, neg, filt;
    logic [3:0] spd;
    logic [3:0] rise_tab = 4'b1011;
    logic [3:0] fall_tab = 4'b1101;
    int miscompares, n_checks, smp1, evt0;
    analog_comparator_control #(.NCH(2), .STARTUP_CYCLES(SU)) dut_u (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .comp_out(comp_out), .core_power_on(pwr), .core_sample(smp),
        .positive_input_select(pos), .negative_input_select(neg), .hysteresis_select(hys),
        .speed_select(spd), .output_filter_length(filt), .keep_running_in_standby(stby),
        .event_out(evt), .eoc_event(eoc), .irq(irq));
    acmp_core_model #(.NCH(2)) core_u (.aclk(aclk), .core_power_on(pwr), .level(level),
        .comp_out(comp_out));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) if (smp[1]) smp1 <= smp1 + 1;
    always @(posedge aclk) if (evt[0]) evt0 <= evt0 + 1;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask
    task automatic end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_of_test();
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, level, smp1} = '0;
        wstrb = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`OFF_CHAN_CTRL0); check(rd, `RESET_WORD);
        rdr(`OFF_READY); check(rd, 32'h0000_0000);
        rdr(8'h40); check(32'(rs), 32'h0000_0002);
        $display("reset test done");
        wr(`OFF_GLOBAL_CTRL, 32'h0000_0001);
        wr(`OFF_CHAN_CTRL0, 32'h0002_5354);
        check(32'({filt[2:0], neg[2:0], pos[2:0], hys[0], spd[1:0]}), 32'h0000_055D);
        wr(`OFF_CHAN_CTRL0, 32'h0002_5355);
        repeat (SU + 6) @(posedge aclk);
        rdr(`OFF_READY); check(rd[0], 1'b1);
        check(pwr[0], 1'b1);
        wr(`OFF_CHAN_CTRL0, 32'h0000_0001);
        rdr(`OFF_CHAN_CTRL0); check(rd, 32'h0002_5355);
        $display("config test done");
        wr(`OFF_IRQ_ENABLE, 32'h0000_0001);
        for (int s = 0; s < 4; s++) begin
            wr(`OFF_CHAN_CTRL0, 32'(s) << 4);
            level[0] <= 1'b0;
            wr(`OFF_CHAN_CTRL0, (32'(s) << 4) | 32'h0000_0001);
            repeat (8) @(posedge aclk);
            wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
            level[0] <= 1'b1;
            repeat (4) @(posedge aclk);
            rdr(`OFF_IRQ_STATUS); check(rd[0], rise_tab[s]);
            rdr(`OFF_OUT_STATE); check(rd[0], 1'b1);
            wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
            level[0] <= 1'b0;
            repeat (4) @(posedge aclk);
            rdr(`OFF_IRQ_STATUS); check(rd[0], fall_tab[s]);
            check(irq, fall_tab[s]);
        end
        check(32'(evt0), 32'h0000_0008);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        check(eoc[0], 1'b1);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        check(irq, 1'b1);
        $display("irq test done");
        wr(`OFF_GLOBAL_CTRL, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        check(pwr[0], 1'b0);
        rdr(`OFF_CHAN_CTRL0); check(rd[0], 1'b1);
        wr(`OFF_GLOBAL_CTRL, 32'h0000_0001);
        wr(`OFF_CHAN_CTRL0, 32'h0000_0030);
        repeat (2) @(posedge aclk);
        check(pwr[0], 1'b0);
        rdr(`OFF_READY); check(rd[0], 1'b0);
        $display("disable test done");
        wr(`OFF_CHAN_CTRL0 + 8'h04, 32'h0000_00B2);
        wr(`OFF_CHAN_CTRL0 + 8'h04, 32'h0000_00B3);
        check(stby[1], 1'b1);
        wr(`OFF_IRQ_CLEAR, 32'h0000_0003);
        wr(`OFF_IRQ_ENABLE, 32'h0000_0002);
        repeat (SU + 6) @(posedge aclk);
        rdr(`OFF_READY); check(rd[1], 1'b0);
        smp1 = 0;
        wr(`OFF_START, 32'h0000_0002);
        repeat (SU + 10) @(posedge aclk);
        check(32'(smp1), 32'h0000_0001);
        rdr(`OFF_READY); check(rd[1], 1'b1);
        rdr(`OFF_IRQ_STATUS); check(rd[1], 1'b1);
        $display("single test done");
        end_of_test();
    end
endmodule // analog_comparator_control_tb
